// ### design/fprs_defs.vh
// Constants for the floating-point register stack: widths, status fields, opcodes, resets.
`ifndef FPRS_DEFS_VH
`define FPRS_DEFS_VH
`define FPRS_DATA_W      80
`define FPRS_NREG        8
`define FPRS_SW_W        16
// Status word field positions.
`define FPRS_SW_IE       0
`define FPRS_SW_SF       6
`define FPRS_SW_ES       7
`define FPRS_SW_C0       8
`define FPRS_SW_C1       9
`define FPRS_SW_C2       10
`define FPRS_SW_TOP_LO   11
`define FPRS_SW_TOP_HI   13
`define FPRS_SW_C3       14
`define FPRS_SW_BUSY     15
`define FPRS_SW_RESET    16'h0000
`define FPRS_TOP_RESET   3'h0
`define FPRS_CW_RESET    16'h037F
`define FPRS_TW_RESET    16'hFFFF
// Operand formats.
`define FPRS_FMT_EXT     2'h0
`define FPRS_FMT_REAL    2'h1
`define FPRS_FMT_INT     2'h2
`define FPRS_FMT_BCD     2'h3
// Operations.
`define FPRS_OP_NOP      4'h0
`define FPRS_OP_LOAD     4'h1
`define FPRS_OP_STORE    4'h2
`define FPRS_OP_STORE_P  4'h3
`define FPRS_OP_XCHG     4'h4
`define FPRS_OP_WRITE    4'h5
`define FPRS_OP_STSW     4'h6
`define FPRS_OP_STENV    4'h7
`define FPRS_OP_SAVE     4'h8
`define FPRS_OP_CLEX     4'h9
`define FPRS_OP_INIT     4'hA
`define FPRS_OP_FREE     4'hB
`endif

// ### design/fprs_regbank.v
// Eight-entry 80-bit data register bank with two write ports and two registered read ports.
`timescale 1ns/1ps
module fprs_regbank
(
   input  wire        i_mclk,
   input  wire [2:0]  i_wr_addr,
   input  wire [79:0] i_wr_data,
   input  wire        i_wr_en,
   input  wire [2:0]  i_wr2_addr,
   input  wire [79:0] i_wr2_data,
   input  wire        i_wr2_en,
   input  wire [2:0]  i_rd_addr,
   input  wire [2:0]  i_rd2_addr,
   output reg  [79:0] o_rd_data,
   output reg  [79:0] o_rd2_data
);
   reg [79:0] mem_q [0:7];

   // Contents change only on an explicit write; nothing else, reset included, touches them.
   always @(posedge i_mclk)
   begin
      if (i_wr_en)
         mem_q[i_wr_addr] <= i_wr_data;
      if (i_wr2_en)
         mem_q[i_wr2_addr] <= i_wr2_data;
      o_rd_data  <= mem_q[i_rd_addr];
      o_rd2_data <= mem_q[i_rd2_addr];
   end
endmodule

// ### design/fprs_stack.v
// Floating-point data register stack with head pointer, tags and status word.
`timescale 1ns/1ps
`include "fprs_defs.vh"
module fprs_stack
(
   input  wire        i_mclk,
   input  wire        i_rst,
   input  wire        i_op_valid,
   input  wire [3:0]  i_op,
   input  wire [2:0]  i_rel_idx,
   input  wire [1:0]  i_fmt,
   input  wire [79:0] i_mem_data,
   input  wire [15:0] i_ctrl_wr,
   input  wire        i_ctrl_we,
   input  wire [47:0] i_instr_ptr,
   input  wire [47:0] i_oper_ptr,
   input  wire [10:0] i_opcode,
   output reg  [79:0] o_mem_data,
   output reg  [1:0]  o_mem_fmt,
   output reg         o_mem_valid,
   output reg  [15:0] o_int_accumulator,
   output reg         o_acc_valid,
   output wire [15:0] o_fp_status_word,
   output reg  [15:0] o_ctrl_word,
   output reg  [15:0] o_tag_word,
   output reg  [47:0] o_last_instr_ptr,
   output reg  [47:0] o_last_oper_ptr,
   output reg  [10:0] o_last_opcode
);
   reg  [2:0]  top_q;
   reg  [15:0] sw_q;
   reg  [7:0]  full_q;
   reg  [3:0]  pend_op_q;
   reg  [1:0]  pend_fmt_q;
   wire [2:0]  top_dec;
   wire [2:0]  top_inc;
   wire [2:0]  rel_phys;
   wire [79:0] rd_head;
   wire [79:0] rd_rel;
   wire [79:0] load_ext;
   reg         wr_en;
   reg  [2:0]  wr_addr;
   reg  [79:0] wr_data;
   reg         wr2_en;
   reg         fault;
   reg         ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Head arithmetic; the 3-bit wrap gives modulo-eight behaviour for free.
   assign top_dec  = top_q - 3'h1;
   assign top_inc  = top_q + 3'h1;
   assign rel_phys = top_q + i_rel_idx;

   // Status word with the live head pointer merged into its field.
   assign o_fp_status_word = {sw_q[15:14], top_q, sw_q[10:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Format widening: a simple placement of the narrow value into the extended
   // word. Full numeric conversion is beyond this block; the caller is expected
   // to present a pre-normalised mantissa in the low bits.
   function [79:0] fprs_widen;
      input [79:0] v;
      input [1:0]  f;
      begin
         if (f == `FPRS_FMT_EXT)
            fprs_widen = v;
         else if (f == `FPRS_FMT_REAL)
            fprs_widen = {v[63], 15'h3FFF, 1'b1, v[62:0]};
         else if (f == `FPRS_FMT_INT)
            fprs_widen = {1'b0, 15'h403E, v[63:0]};
         else
            fprs_widen = {v[79], 15'h4042, v[63:0]};
      end
   endfunction

   function [79:0] fprs_narrow;
      input [79:0] v;
      input [1:0]  f;
      begin
         if (f == `FPRS_FMT_EXT)
            fprs_narrow = v;
         else if (f == `FPRS_FMT_REAL)
            fprs_narrow = {16'h0000, v[79], v[62:0]};
         else if (f == `FPRS_FMT_INT)
            fprs_narrow = {16'h0000, v[63:0]};
         else
            fprs_narrow = {v[79], 15'h0000, v[63:0]};
      end
   endfunction

   assign load_ext = fprs_widen(i_mem_data, i_fmt);

   ////////////////////////////////////////////////////////////////////////////
   // Write-port steering and fault detection for the current operation.
   always @*
   begin
      wr_en   = 1'b0;
      wr2_en  = 1'b0;
      wr_addr = top_q;
      wr_data = load_ext;
      fault   = 1'b0;
      ovf     = 1'b0;
      if (i_op_valid)
      begin
         case (i_op)
            `FPRS_OP_LOAD:
            begin
               wr_addr = top_dec;
               if (full_q[top_dec])
               begin
                  fault = 1'b1;
                  ovf   = 1'b1;
               end
               else
                  wr_en = 1'b1;
            end
            `FPRS_OP_WRITE:
            begin
               wr_addr = rel_phys;
               wr_en   = 1'b1;
            end
            `FPRS_OP_STORE, `FPRS_OP_STORE_P:
               fault = ~full_q[top_q];
            `FPRS_OP_XCHG:
            begin
               fault = ~full_q[top_q] | ~full_q[rel_phys];
               wr_en  = ~fault;
               wr2_en = ~fault;
               wr_addr = top_q;
               wr_data = rd_rel;
            end
            default:
               fault = 1'b0;
         endcase
      end
   end

   // The exchange needs both operands read ahead of the write, so the bank
   // reads are combinationally addressed but the caller holds i_rel_idx for
   // the cycle before the exchange; rd ports register on every edge.
   fprs_regbank u_bank
   (
      .i_mclk     (i_mclk),
      .i_wr_addr  (wr_addr),
      .i_wr_data  (wr_data),
      .i_wr_en    (wr_en),
      .i_wr2_addr (rel_phys),
      .i_wr2_data (rd_head),
      .i_wr2_en   (wr2_en),
      .i_rd_addr  (top_q),
      .i_rd2_addr (rel_phys),
      .o_rd_data  (rd_head),
      .o_rd2_data (rd_rel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Head, tag occupancy and status word.
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         top_q  <= `FPRS_TOP_RESET;
         sw_q   <= `FPRS_SW_RESET;
         full_q <= 8'h00;
      end
      else if (i_op_valid)
      begin
         sw_q[`FPRS_SW_BUSY] <= 1'b0;
         if (fault)
         begin
            sw_q[`FPRS_SW_IE] <= 1'b1;
            sw_q[`FPRS_SW_SF] <= 1'b1;
            sw_q[`FPRS_SW_ES] <= ~o_ctrl_word[0];
            sw_q[`FPRS_SW_C1] <= ovf;
         end
         else
            sw_q[`FPRS_SW_C1] <= 1'b0;
         case (i_op)
            `FPRS_OP_LOAD:
               if (!fault)
               begin
                  top_q            <= top_dec;
                  full_q[top_dec]  <= 1'b1;
               end
            `FPRS_OP_STORE_P:
               if (!fault)
               begin
                  top_q           <= top_inc;
                  full_q[top_q]   <= 1'b0;
               end
            `FPRS_OP_WRITE:
               full_q[rel_phys] <= 1'b1;
            `FPRS_OP_FREE:
               full_q[rel_phys] <= 1'b0;
            `FPRS_OP_CLEX:
               sw_q <= {sw_q[15:8], 8'h00};
            `FPRS_OP_INIT, `FPRS_OP_SAVE:
            begin
               top_q  <= `FPRS_TOP_RESET;
               sw_q   <= `FPRS_SW_RESET;
               full_q <= 8'h00;
            end
            default:
               top_q <= top_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output side: store data one cycle after the bank read, status copies.
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pend_op_q         <= `FPRS_OP_NOP;
         pend_fmt_q        <= `FPRS_FMT_EXT;
         o_mem_data        <= 80'h0000;
         o_mem_fmt         <= `FPRS_FMT_EXT;
         o_mem_valid       <= 1'b0;
         o_int_accumulator <= 16'h0000;
         o_acc_valid       <= 1'b0;
      end
      else
      begin
         pend_op_q   <= (i_op_valid && !fault) ? i_op : `FPRS_OP_NOP;
         pend_fmt_q  <= i_fmt;
         o_mem_valid <= 1'b0;
         o_acc_valid <= 1'b0;
         if (pend_op_q == `FPRS_OP_STORE || pend_op_q == `FPRS_OP_STORE_P)
         begin
            o_mem_data  <= fprs_narrow(rd_head, pend_fmt_q);
            o_mem_fmt   <= pend_fmt_q;
            o_mem_valid <= 1'b1;
         end
         if (i_op_valid && (i_op == `FPRS_OP_STSW || i_op == `FPRS_OP_STENV ||
             i_op == `FPRS_OP_SAVE))
         begin
            o_mem_data  <= {64'h0000_0000_0000_0000, o_fp_status_word};
            o_mem_fmt   <= `FPRS_FMT_INT;
            o_mem_valid <= 1'b1;
         end
         if (i_op_valid && i_op == `FPRS_OP_STSW)
         begin
            o_int_accumulator <= o_fp_status_word;
            o_acc_valid       <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Environment registers kept beside the stack.
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ctrl_word      <= `FPRS_CW_RESET;
         o_tag_word       <= `FPRS_TW_RESET;
         o_last_instr_ptr <= 48'h0000_0000_0000;
         o_last_oper_ptr  <= 48'h0000_0000_0000;
         o_last_opcode    <= 11'h000;
      end
      else
      begin
         if (i_ctrl_we)
            o_ctrl_word <= i_ctrl_wr;
         o_tag_word <= {{2{~full_q[7]}}, {2{~full_q[6]}}, {2{~full_q[5]}}, {2{~full_q[4]}},
                        {2{~full_q[3]}}, {2{~full_q[2]}}, {2{~full_q[1]}}, {2{~full_q[0]}}};
         if (i_op_valid)
         begin
            o_last_instr_ptr <= i_instr_ptr;
            o_last_oper_ptr  <= i_oper_ptr;
            o_last_opcode    <= i_opcode;
         end
      end
   end
endmodule

// ### bench/fprs_stack_asserts.sv
// Port assertions for the register stack, bound into the stack module.
`timescale 1ns/1ps
`include "fprs_defs.vh"
module fprs_chk
(
   input wire        i_mclk,
   input wire        i_rst,
   input wire        i_op_valid,
   input wire [3:0]  i_op,
   input wire [15:0] i_ctrl_wr,
   input wire        i_ctrl_we,
   input wire        o_mem_valid,
   input wire [15:0] o_int_accumulator,
   input wire        o_acc_valid,
   input wire [15:0] o_fp_status_word,
   input wire [15:0] o_ctrl_word
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   wire [2:0] head   = o_fp_status_word[13:11];
   wire       st_req = i_op_valid && (i_op == `FPRS_OP_STORE || i_op == `FPRS_OP_STORE_P);
   wire       sw_req = i_op_valid && i_op >= `FPRS_OP_STSW && i_op <= `FPRS_OP_SAVE;
   wire       stsw   = i_op_valid && i_op == `FPRS_OP_STSW;
   sequence s_push;
      i_op_valid && i_op == `FPRS_OP_LOAD;
   endsequence
   sequence s_pop;
      i_op_valid && i_op == `FPRS_OP_STORE_P;
   endsequence
   // A refused step keeps the head, so the step is allowed to be zero only while the stack-fault bit 6 is set.
   AST_PUSH_HEAD: assert property (s_push |=> head == $past(head) - 3'h1
      || (head == $past(head) && o_fp_status_word[6])) else $error("push step wrong");
   AST_POP_HEAD: assert property (s_pop |=> head == $past(head) + 3'h1
      || (head == $past(head) && o_fp_status_word[6])) else $error("pop step wrong");
   AST_MEM_CAUSE: assert property (o_mem_valid |-> $past(st_req, 2) || $past(sw_req))
      else $error("memory output without request");
   AST_STSW_OUT: assert property (stsw |=> o_mem_valid && o_acc_valid)
      else $error("status copy missing");
   AST_ACC: assert property (o_acc_valid |-> o_int_accumulator == $past(o_fp_status_word))
      else $error("accumulator copy wrong");
   AST_FAULT_C1: assert property ($rose(o_fp_status_word[6]) |-> o_fp_status_word[0]
      && o_fp_status_word[9] == ($past(i_op) == `FPRS_OP_LOAD)) else $error("fault code wrong");
   AST_IDLE_HEAD: assert property (!i_op_valid |=> $stable(head))
      else $error("head moved while idle");
   AST_CTRL: assert property (i_ctrl_we |=> o_ctrl_word == $past(i_ctrl_wr))
      else $error("control word not written");
endmodule
////////////////////////////////////////////////////////////
bind fprs_stack fprs_chk u_chk
(
   .i_mclk, .i_rst, .i_op_valid, .i_op, .i_ctrl_wr, .i_ctrl_we, .o_mem_valid,
   .o_int_accumulator, .o_acc_valid, .o_fp_status_word, .o_ctrl_word
);

// ### bench/fprs_host.sv
// Host sequencer model that issues stack operations and control word writes.
`timescale 1ns/1ps
module fprs_host
(
   input  wire        i_mclk,
   output reg         o_op_valid,
   output reg  [3:0]  o_op,
   output reg  [2:0]  o_rel_idx,
   output reg  [1:0]  o_fmt,
   output reg  [79:0] o_mem_data,
   output reg  [15:0] o_ctrl_wr,
   output reg         o_ctrl_we,
   output reg  [47:0] o_instr_ptr,
   output reg  [47:0] o_oper_ptr,
   output reg  [10:0] o_opcode
);
   initial
   begin
      o_op_valid = 1'b0;
      o_op = 4'h0;
      o_rel_idx = 3'h0;
      o_fmt = 2'h0;
      o_mem_data = 80'h0;
      o_ctrl_wr = 16'h0;
      o_ctrl_we = 1'b0;
      o_instr_ptr = 48'h0;
      o_oper_ptr = 48'h0;
      o_opcode = 11'h0;
   end
   // One operation per cycle from the shared decoder; idle data is scrambled.
   task step(input logic v, input logic [3:0] c, input logic [2:0] i, input logic [79:0] d);
   begin
      @(posedge i_mclk);
      #1;
      o_op_valid = v;
      o_op = c;
      o_rel_idx = i;
      o_mem_data = v ? d : ~o_mem_data;
      o_ctrl_we = 1'b0;
      o_opcode = {7'h00, c};
      o_instr_ptr = o_instr_ptr + 48'h1;
      o_oper_ptr = ~o_instr_ptr;
   end
   endtask
   // The format is a level; call it right after a step so it stands before the take.
   task fmt(input logic [1:0] f);
   begin
      o_fmt = f;
   end
   endtask
   task cw(input logic [15:0] w);
   begin
      @(posedge i_mclk);
      #1;
      o_op_valid = 1'b0;
      o_ctrl_wr = w;
      o_ctrl_we = 1'b1;
   end
   endtask
endmodule

// ### bench/fprs_stack_test.sv
// Self-checking bench for the register stack: pushes, stores, wrap, faults, status.
`timescale 1ns/1ps
`include "fprs_defs.vh"
module fprs_stack_test;
   typedef struct {logic [3:0] op; logic [2:0] idx; logic [79:0] d; logic [2:0] head;} row_t;
   logic        i_mclk = 1'b0;
   logic        i_rst = 1'b1;
   wire         i_op_valid, i_ctrl_we, o_mem_valid, o_acc_valid;
   wire [3:0]   i_op;
   wire [2:0]   i_rel_idx;
   wire [1:0]   i_fmt, o_mem_fmt;
   wire [79:0]  i_mem_data, o_mem_data;
   wire [15:0]  i_ctrl_wr, o_int_accumulator, o_fp_status_word, o_ctrl_word, o_tag_word;
   wire [47:0]  i_instr_ptr, i_oper_ptr, o_last_instr_ptr, o_last_oper_ptr;
   wire [10:0]  i_opcode, o_last_opcode;
   row_t        rows[17];
   int          n_fail = 0;
   int          n_checks = 0;
   always #5 i_mclk = ~i_mclk;
   fprs_host u_host (.i_mclk, .o_op_valid(i_op_valid), .o_op(i_op), .o_rel_idx(i_rel_idx),
      .o_fmt(i_fmt), .o_mem_data(i_mem_data), .o_ctrl_wr(i_ctrl_wr), .o_ctrl_we(i_ctrl_we),
      .o_instr_ptr(i_instr_ptr), .o_oper_ptr(i_oper_ptr), .o_opcode(i_opcode));
   fprs_stack u_dut (.i_mclk, .i_rst, .i_op_valid, .i_op, .i_rel_idx, .i_fmt, .i_mem_data,
      .i_ctrl_wr, .i_ctrl_we, .i_instr_ptr, .i_oper_ptr, .i_opcode, .o_mem_data, .o_mem_fmt,
      .o_mem_valid, .o_int_accumulator, .o_acc_valid, .o_fp_status_word, .o_ctrl_word,
      .o_tag_word, .o_last_instr_ptr, .o_last_oper_ptr, .o_last_opcode);
   ////////////////////////////////////////////////////////////
   function automatic logic [79:0] val(input int k);
      return {20{k[3:0]}};
   endfunction
   task chk16(input logic [15:0] g, input logic [15:0] e);
   begin
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task chk80(input logic [79:0] g, input logic [79:0] e);
   begin
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task test_done;
   begin
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   task go(input logic [3:0] c);
   begin
      u_host.step(1'b1, c, 3'h0, 80'h0);
      u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
   end
   endtask
   // A pop answers two edges after the take, so its data is looked at one cycle later.
   task pop(input logic [79:0] e);
   begin
      go(`FPRS_OP_STORE_P);
      u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
      chk80(o_mem_data, e);
   end
   endtask
   localparam logic [79:0] rt_d = 80'h8765_1234_5678_9ABC_DEF0;
   // Load in one format and pop straight back in the same format.
   task rt(input logic [1:0] f, input logic [79:0] e);
   begin
      u_host.step(1'b1, `FPRS_OP_LOAD, 3'h0, rt_d);
      u_host.fmt(f);
      u_host.step(1'b1, `FPRS_OP_STORE_P, 3'h0, 80'h0);
      u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
      u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
      chk80(o_mem_data, e);
      chk16({14'h0, o_mem_fmt}, {14'h0, f});
   end
   endtask
   // Stores answer two edges after the take, so each store row waits one more cycle.
   task run(input int lo, input int hi);
   begin
      for (int r = lo; r <= hi; r++)
      begin
         u_host.step(1'b1, rows[r].op, rows[r].idx, rows[r].d);
         u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
         chk16({13'h0, o_fp_status_word[13:11]}, {13'h0, rows[r].head});
         if (rows[r].op != `FPRS_OP_LOAD)
         begin
            u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
            chk16({15'h0, o_mem_valid}, 16'h0001);
            chk80(o_mem_data, rows[r].d);
         end
      end
   end
   endtask
   initial
   begin
      #100000;
      n_fail++;
      test_done();
   end
   initial
   begin
      for (int k = 0; k < 8; k++)
         rows[k] = '{`FPRS_OP_LOAD, 3'h0, val(k + 1), 3'(7 - k)};
      rows[8] = '{`FPRS_OP_STORE, 3'h2, val(8), 3'h0};
      for (int j = 0; j < 8; j++)
         rows[9 + j] = '{`FPRS_OP_STORE_P, 3'h0, val(8 - j), 3'(j + 1)};
      repeat (2) @(posedge i_mclk);
      #1;
      i_rst = 1'b0;
      chk16(o_fp_status_word, 16'h0000);
      chk16(o_ctrl_word, 16'h037F);
      chk16(o_tag_word, 16'hFFFF);
      run(0, 7);
      go(`FPRS_OP_LOAD);
      go(`FPRS_OP_STSW);
      chk16(o_int_accumulator, 16'h0241);
      chk16(o_mem_data[15:0], 16'h0241);
      chk16({14'h0, o_mem_fmt}, {14'h0, `FPRS_FMT_INT});
      chk16({5'h0, o_last_opcode}, {12'h0, `FPRS_OP_STSW});
      chk80({32'h0, o_last_instr_ptr}, {32'h0, i_instr_ptr - 48'h1});
      chk80({32'h0, o_last_oper_ptr}, {32'h0, ~(i_instr_ptr - 48'h1)});
      go(`FPRS_OP_CLEX);
      chk16(o_fp_status_word, 16'h0000);
      run(8, 16);
      u_host.cw(16'h037E);
      go(`FPRS_OP_STORE_P);
      chk16(o_fp_status_word, 16'h00C1);
      u_host.step(1'b0, 4'h0, 3'h0, 80'h0);
      chk16({15'h0, o_mem_valid}, 16'h0000);
      rt(`FPRS_FMT_REAL, 80'h0000_1234_5678_9ABC_DEF0);
      rt(`FPRS_FMT_INT, 80'h0000_1234_5678_9ABC_DEF0);
      rt(`FPRS_FMT_BCD, 80'h8000_1234_5678_9ABC_DEF0);
      // Relative write past the wrap, then an exchange with the index held for a cycle.
      u_host.step(1'b1, `FPRS_OP_LOAD, 3'h0, val(10));
      u_host.fmt(`FPRS_FMT_EXT);
      u_host.step(1'b1, `FPRS_OP_LOAD, 3'h0, val(11));
      u_host.step(1'b1, `FPRS_OP_WRITE, 3'h2, val(12));
      u_host.step(1'b0, 4'h0, 3'h2, 80'h0);
      u_host.step(1'b1, `FPRS_OP_XCHG, 3'h2, 80'h0);
      pop(val(12));
      pop(val(10));
      pop(val(11));
      go(`FPRS_OP_SAVE);
      chk16(o_mem_data[15:0], 16'h08C1);
      chk16(o_fp_status_word, 16'h0000);
      go(`FPRS_OP_LOAD);
      @(posedge i_mclk);
      #1;
      i_rst = 1'b1;
      @(posedge i_mclk);
      #1;
      i_rst = 1'b0;
      chk16(o_fp_status_word, 16'h0000);
      chk16(o_tag_word, 16'hFFFF);
      go(`FPRS_OP_LOAD);
      chk16({13'h0, o_fp_status_word[13:11]}, 16'h0007);
      test_done();
   end
endmodule
